/* dmaarb_cfg.svh */
`ifndef DMAARB_CFG_SVH
`define DMAARB_CFG_SVH
// ==========================================================
// channel and width figures
`define DMAARB_NUM_CH 6
`define DMAARB_DATA_W 16
`define DMAARB_ADDR_W 16
// ==========================================================
// transfer timing, cycles of the dma clock
`define DMAARB_INT_RD_CYC 2
`define DMAARB_INT_WR_CYC 2
`define DMAARB_EXT_EXTRA_CYC 1
`define DMAARB_MAX_CLK_DIV 4
`endif

/* dmaarb_pkg.sv */
package dmaarb_pkg;
    // ==========================================================
    // transfer engine states
    typedef enum logic [2:0] {
        DMAARB_IDLE = 3'b000,
        DMAARB_READ = 3'b001,
        DMAARB_WRITE = 3'b010,
        DMAARB_HOST = 3'b011
    } dmaarb_state_t;
    typedef logic [1:0] dmaarb_sleep_t;
endpackage : dmaarb_pkg

/* dmaarb_rr_pick.sv */
`timescale 1ns/10ps
`include "dmaarb_cfg.svh"
module dmaarb_rr_pick
    import dmaarb_pkg::*;
(
    // requests and pointer
    input wire logic [`DMAARB_NUM_CH-1:0] i_req,
    input wire logic [2:0] i_last,
    // result
    output logic o_any,
    output logic [2:0] o_idx
);
    // ==========================================================
    // circular search starting one past the last winner
    function automatic logic [2:0] dmaarb_wrap(input logic [3:0] v);
        dmaarb_wrap = (v >= 4'(`DMAARB_NUM_CH)) ? 3'(v - 4'(`DMAARB_NUM_CH)) : v[2:0];
    endfunction : dmaarb_wrap

    always_comb begin
        logic [2:0] cand;
        cand = 3'h0;
        o_any = 1'b0;
        o_idx = 3'h0;
        for (int k = `DMAARB_NUM_CH; k >= 1; k--) begin
            cand = dmaarb_wrap({1'b0, i_last} + 4'(k));
            if (i_req[cand]) begin
                o_any = 1'b1;
                o_idx = cand;
            end
        end
    end
endmodule : dmaarb_rr_pick

/* dmaarb_phase_timer.sv */
`timescale 1ns/10ps
`include "dmaarb_cfg.svh"
module dmaarb_phase_timer
    import dmaarb_pkg::*;
(
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    // control
    input wire logic i_start,
    input wire logic i_ext,
    input wire logic [1:0] i_ext_div_m1,
    input wire logic [3:0] i_ext_wait,
    // status
    output logic o_done
);
    // ==========================================================
    // phase length: internal base, plus external access stretched by divider
    // seven bits: fifteen waits at quarter rate need a 66-cycle phase
    logic [6:0] cnt_r;
    logic [6:0] cnt_nxt;
    logic busy_r;
    logic busy_nxt;
    logic [6:0] len;

    always_comb begin
        len = 7'(`DMAARB_INT_RD_CYC);
        if (i_ext) begin
            len = 7'(`DMAARB_INT_RD_CYC) +
                  7'((7'(`DMAARB_EXT_EXTRA_CYC) + 7'(i_ext_wait)) * (7'(i_ext_div_m1) + 7'h1));
        end
        cnt_nxt = cnt_r;
        busy_nxt = busy_r;
        o_done = busy_r && (cnt_r == 7'h1);
        if (i_start) begin
            busy_nxt = 1'b1;
            cnt_nxt = len;
        end else if (busy_r) begin
            cnt_nxt = cnt_r - 7'h1;
            if (cnt_r == 7'h1) begin
                busy_nxt = 1'b0;
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            cnt_r <= 7'h0;
            busy_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            busy_r <= busy_nxt;
        end
    end
endmodule : dmaarb_phase_timer

/* dmaarb_core.sv */
`timescale 1ns/10ps
`include "dmaarb_cfg.svh"
// Functional notes
// - each element is a read of the source then a write to destination
// - internal to internal element takes four cycles; one per five per channel, with the idle cycle
// - two cycles read phase, two cycles write phase on chip
// - off-chip phase lengthened by interface cycles and waits
// - zero waits, undivided: one external end gives 5, two give 6
// - on-chip memory and mapped registers both count as internal
// - divided external bus clock slows external phases proportionally
// - high-priority channels served first, rotating circularly
// - low-priority channels only when no high-priority work, also rotated
// - host request waits for current element, then gets bus, channels held
// - after host release, channels resume with state and order intact
// - double-word element never split by host request
// - host port has dedicated arbitration port, uses no channel
// - dual-subsystem variant sends every I/O-space access to the FIFO
// - transfers continue in all three sleep levels
// - internal clocks gated off when no transfer, channel or host request, or end pulse is pending
// - clocks re-enabled for a due transfer, then gated again
// - sleep levels one and two clock from the CPU clock source
// - sleep level three clocks straight from the input clock pin
// - controller can raise an interrupt to wake the CPU
module dmaarb_core
    import dmaarb_pkg::*;
(
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    input wire logic i_input_clock_pin,
    // channel requests
    input wire logic [`DMAARB_NUM_CH-1:0] i_ch_req,
    input wire logic [`DMAARB_NUM_CH-1:0] i_ch_high,
    input wire logic [`DMAARB_NUM_CH-1:0] i_ch_dbl,
    input wire logic [`DMAARB_NUM_CH-1:0] i_ch_src_ext,
    input wire logic [`DMAARB_NUM_CH-1:0] i_ch_dst_ext,
    input wire logic [`DMAARB_NUM_CH-1:0] i_ch_src_io,
    input wire logic [`DMAARB_NUM_CH-1:0] i_ch_dst_io,
    input wire logic [`DMAARB_NUM_CH-1:0] i_ch_irq_en,
    // external interface conditions
    input wire logic [1:0] i_ext_div_m1,
    input wire logic [3:0] i_ext_wait,
    input wire logic i_dual_subsys,
    // sleep
    input wire logic [1:0] i_sleep_level,
    // host access port
    input wire logic i_host_access_port_req,
    // data path
    input wire logic [`DMAARB_DATA_W-1:0] i_rd_data,
    // channel side answers
    output logic [`DMAARB_NUM_CH-1:0] o_ch_elem_done,
    output logic o_ch_active,
    output logic [2:0] o_ch_idx,
    // bus strobes
    output logic o_rd_stb,
    output logic o_wr_stb,
    output logic o_word_half,
    output logic o_fifo_sel,
    output logic [`DMAARB_DATA_W-1:0] o_wr_data,
    // host port
    output logic o_host_access_port_gnt,
    // clocking and wake
    output logic o_dma_clk_en,
    output logic o_dma_clk_sel_pin,
    output logic o_wake_irq
);
    // ==========================================================
    // state
    dmaarb_state_t st_r;
    dmaarb_state_t st_nxt;
    logic [2:0] ch_r;
    logic [2:0] ch_nxt;
    logic [2:0] last_hi_r;
    logic [2:0] last_hi_nxt;
    logic [2:0] last_lo_r;
    logic [2:0] last_lo_nxt;
    logic half_r;
    logic half_nxt;
    logic [`DMAARB_DATA_W-1:0] data_r;
    logic [`DMAARB_DATA_W-1:0] data_nxt;
    logic [`DMAARB_NUM_CH-1:0] done_r;
    logic [`DMAARB_NUM_CH-1:0] done_nxt;
    logic irq_r;
    logic irq_nxt;
    logic rd_stb_r;
    logic rd_stb_nxt;
    logic wr_stb_r;
    logic wr_stb_nxt;
    logic fifo_r;
    logic fifo_nxt;
    logic take;
    logic elem_end;

    // ==========================================================
    // arbitration
    logic [`DMAARB_NUM_CH-1:0] hi_req;
    logic [`DMAARB_NUM_CH-1:0] lo_req;
    logic hi_any;
    logic lo_any;
    logic [2:0] hi_idx;
    logic [2:0] lo_idx;

    assign hi_req = i_ch_req & i_ch_high;
    assign lo_req = i_ch_req & ~i_ch_high;

    dmaarb_rr_pick u_pick_hi (
        .i_req(hi_req),
        .i_last(last_hi_r),
        .o_any(hi_any),
        .o_idx(hi_idx)
    );

    dmaarb_rr_pick u_pick_lo (
        .i_req(lo_req),
        .i_last(last_lo_r),
        .o_any(lo_any),
        .o_idx(lo_idx)
    );

    // ==========================================================
    // phase timing
    logic tmr_start;
    logic tmr_ext;
    logic tmr_done;

    dmaarb_phase_timer u_timer (
        .i_ref_clk(i_ref_clk),
        .i_resetn(i_resetn),
        .i_start(tmr_start),
        .i_ext(tmr_ext),
        .i_ext_div_m1(i_ext_div_m1),
        .i_ext_wait(i_ext_wait),
        .o_done(tmr_done)
    );

    // io space is never external on the dual-subsystem part
    function automatic logic dmaarb_is_ext(input logic ext, input logic io);
        dmaarb_is_ext = ext && !(io && i_dual_subsys);
    endfunction : dmaarb_is_ext

    function automatic logic dmaarb_is_fifo(input logic io);
        dmaarb_is_fifo = io && i_dual_subsys;
    endfunction : dmaarb_is_fifo

    // ==========================================================
    // engine
    always_comb begin
        st_nxt = st_r;
        ch_nxt = ch_r;
        half_nxt = half_r;
        take = 1'b0;
        elem_end = 1'b0;
        rd_stb_nxt = 1'b0;
        wr_stb_nxt = 1'b0;
        fifo_nxt = fifo_r;
        tmr_start = 1'b0;
        tmr_ext = 1'b0;
        case (st_r)
            DMAARB_IDLE: begin
                // host wins only at an element boundary
                if (i_host_access_port_req) begin
                    st_nxt = DMAARB_HOST;
                end else if (hi_any || lo_any) begin
                    ch_nxt = hi_any ? hi_idx : lo_idx;
                    take = 1'b1;
                    half_nxt = 1'b0;
                    st_nxt = DMAARB_READ;
                    tmr_start = 1'b1;
                    tmr_ext = dmaarb_is_ext(i_ch_src_ext[ch_nxt], i_ch_src_io[ch_nxt]);
                    rd_stb_nxt = 1'b1;
                    fifo_nxt = dmaarb_is_fifo(i_ch_src_io[ch_nxt]);
                end
            end
            DMAARB_READ: begin
                if (tmr_done) begin
                    st_nxt = DMAARB_WRITE;
                    tmr_start = 1'b1;
                    tmr_ext = dmaarb_is_ext(i_ch_dst_ext[ch_r], i_ch_dst_io[ch_r]);
                    wr_stb_nxt = 1'b1;
                    fifo_nxt = dmaarb_is_fifo(i_ch_dst_io[ch_r]);
                end
            end
            DMAARB_WRITE: begin
                if (tmr_done) begin
                    if (i_ch_dbl[ch_r] && !half_r) begin
                        // second half runs before any host grant
                        half_nxt = 1'b1;
                        st_nxt = DMAARB_READ;
                        tmr_start = 1'b1;
                        tmr_ext = dmaarb_is_ext(i_ch_src_ext[ch_r], i_ch_src_io[ch_r]);
                        rd_stb_nxt = 1'b1;
                        fifo_nxt = dmaarb_is_fifo(i_ch_src_io[ch_r]);
                    end else begin
                        elem_end = 1'b1;
                        st_nxt = DMAARB_IDLE;
                    end
                end
            end
            DMAARB_HOST: begin
                // pointers untouched while host owns the bus
                if (!i_host_access_port_req) begin
                    st_nxt = DMAARB_IDLE;
                end
            end
            default: begin
                st_nxt = DMAARB_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            st_r <= DMAARB_IDLE;
            ch_r <= 3'h0;
            half_r <= 1'b0;
            done_r <= '0;
            irq_r <= 1'b0;
            rd_stb_r <= 1'b0;
            wr_stb_r <= 1'b0;
            fifo_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            ch_r <= ch_nxt;
            half_r <= half_nxt;
            done_r <= done_nxt;
            irq_r <= irq_nxt;
            rd_stb_r <= rd_stb_nxt;
            wr_stb_r <= wr_stb_nxt;
            fifo_r <= fifo_nxt;
        end
    end

    // ==========================================================
    // round-robin pointers, moved only when an element is taken
    always_comb begin
        last_hi_nxt = last_hi_r;
        last_lo_nxt = last_lo_r;
        if (take && hi_any) begin
            last_hi_nxt = hi_idx;
        end else if (take) begin
            last_lo_nxt = lo_idx;
        end
    end

    // reset to the top channel so that channel 0 leads the first rotation
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            last_hi_r <= 3'(`DMAARB_NUM_CH - 1);
            last_lo_r <= 3'(`DMAARB_NUM_CH - 1);
        end else begin
            last_hi_r <= last_hi_nxt;
            last_lo_r <= last_lo_nxt;
        end
    end

    // ==========================================================
    // write data, loaded as the read phase closes
    always_comb begin
        data_nxt = data_r;
        if ((st_r == DMAARB_READ) && tmr_done) begin
            data_nxt = i_rd_data;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            data_r <= '0;
        end else begin
            data_r <= data_nxt;
        end
    end

    // ==========================================================
    // per-channel end pulse and wake request
    logic [`DMAARB_NUM_CH-1:0] wake_vec;
    genvar g;
    generate
        for (g = 0; g < `DMAARB_NUM_CH; g++) begin : g_end
            assign done_nxt[g] = elem_end && (ch_r == 3'(g));
            assign wake_vec[g] = done_nxt[g] && i_ch_irq_en[g];
        end
    endgenerate
    // raised in every sleep level; the cpu side decides whether it wakes
    assign irq_nxt = |wake_vec;

    // ==========================================================
    // outputs
    assign o_ch_elem_done = done_r;
    assign o_ch_active = (st_r == DMAARB_READ) || (st_r == DMAARB_WRITE);
    assign o_ch_idx = ch_r;
    assign o_rd_stb = rd_stb_r;
    assign o_wr_stb = wr_stb_r;
    assign o_word_half = half_r;
    assign o_fifo_sel = fifo_r;
    assign o_wr_data = data_r;
    assign o_host_access_port_gnt = (st_r == DMAARB_HOST);
    assign o_wake_irq = irq_r;
    // clock gate: on for pending or running work in every sleep level
    // end pulses need one more edge to clear, so the gate stays open for them
    assign o_dma_clk_en = o_ch_active || (|i_ch_req) || i_host_access_port_req
                          || (|done_r);
    // level three: raw pin clock, otherwise the cpu source
    assign o_dma_clk_sel_pin = (i_sleep_level == 2'h3) && i_input_clock_pin;
endmodule : dmaarb_core

/* dmaarb_core_properties.sv */
`timescale 1ns/10ps
`include "dmaarb_cfg.svh"
// ==========================================================
// port checks of the transfer engine
module dmaarb_core_check
    import dmaarb_pkg::*;
#(
    parameter int N = `DMAARB_NUM_CH
)(
    // clock, reset and inputs
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    input wire logic i_input_clock_pin,
    input wire logic [N-1:0] i_ch_req,
    input wire logic [N-1:0] i_ch_high,
    input wire logic [N-1:0] i_ch_dbl,
    input wire logic [N-1:0] i_ch_src_ext,
    input wire logic [N-1:0] i_ch_dst_ext,
    input wire logic [N-1:0] i_ch_src_io,
    input wire logic [N-1:0] i_ch_dst_io,
    input wire logic [N-1:0] i_ch_irq_en,
    input wire logic [1:0] i_ext_div_m1,
    input wire logic [3:0] i_ext_wait,
    input wire logic [1:0] i_sleep_level,
    input wire logic i_dual_subsys,
    input wire logic i_host_access_port_req,
    // outputs watched
    input wire logic [N-1:0] o_ch_elem_done,
    input wire logic o_ch_active,
    input wire logic [2:0] o_ch_idx,
    input wire logic o_rd_stb,
    input wire logic o_wr_stb,
    input wire logic o_word_half,
    input wire logic o_host_access_port_gnt,
    input wire logic o_dma_clk_en,
    input wire logic o_dma_clk_sel_pin,
    input wire logic o_wake_irq
);
    // channel inputs are levels held per element, so indexing by o_ch_idx is safe
    // io space of the dual part is on-chip even when marked off-chip
    wire src_off = i_ch_src_ext[o_ch_idx] && !(i_ch_src_io[o_ch_idx] && i_dual_subsys);
    wire dst_off = i_ch_dst_ext[o_ch_idx] && !(i_ch_dst_io[o_ch_idx] && i_dual_subsys);
    wire fast = (i_ext_wait == 4'h0) && (i_ext_div_m1 == 2'h0);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_resetn);
    // ==========================================================
    // assertions
    rd_wr_gap_a: assert property (o_rd_stb && !src_off |-> ##2 o_wr_stb)
        else $error("internal read phase length wrong");
    ext_rd_a: assert property (o_rd_stb && src_off && fast |-> ##3 o_wr_stb)
        else $error("external read phase length wrong");
    div_rd_a: assert property (
        o_rd_stb && src_off && i_ext_wait == 4'h0 && i_ext_div_m1 == 2'h3
        |=> !o_wr_stb [*5] ##1 o_wr_stb) else $error("divided read phase wrong");
    int_done_a: assert property (
        o_wr_stb && !dst_off && (o_word_half || !i_ch_dbl[o_ch_idx])
        |-> ##2 o_ch_elem_done[o_ch_idx]) else $error("element end late or early");
    gnt_quiet_a: assert property (
        o_host_access_port_gnt |-> !o_ch_active && !o_rd_stb && !o_wr_stb)
        else $error("channel traffic during host grant");
    dbl_whole_a: assert property (
        o_wr_stb && !o_word_half && i_ch_dbl[o_ch_idx] |-> !o_host_access_port_gnt
        throughout (##[1:66] (o_rd_stb && o_word_half))) else $error("double word split");
    prio_high_a: assert property (
        o_rd_stb && !o_word_half |-> i_ch_high[o_ch_idx] || !$past(|(i_ch_high & i_ch_req)))
        else $error("low channel served while high pending");
    clk_on_a: assert property (o_ch_active |-> o_dma_clk_en)
        else $error("clock off during transfer");
    clk_off_a: assert property (
        !o_ch_active && !o_host_access_port_gnt && !o_ch_elem_done && !i_ch_req
        && !i_host_access_port_req |-> !o_dma_clk_en) else $error("clock on while idle");
    sel_pin_a: assert property (
        i_input_clock_pin |-> o_dma_clk_sel_pin == (i_sleep_level == 2'h3))
        else $error("clock source select wrong");
    wake_a: assert property (
        (o_ch_elem_done & i_ch_irq_en) != '0 && i_sleep_level != 2'h0 |-> ##[0:1] o_wake_irq)
        else $error("wake pulse missing");
    host_c: cover property (o_host_access_port_gnt);
    half_c: cover property (o_rd_stb && o_word_half);
    wake_c: cover property (o_wake_irq);
endmodule : dmaarb_core_check

bind dmaarb_core dmaarb_core_check u_chk (.*);

/* dmaarb_host_model.sv */
`timescale 1ns/10ps
// ==========================================================
// host port stand-in: asks for the bus, uses it HOLD+1 granted cycles
module dmaarb_host_model #(
    parameter int HOLD = 3
)(
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    // command and grant
    input wire logic i_go,
    input wire logic i_gnt,
    // request
    output logic o_req
);
    int cnt;
    // request stays up until the grant has been used, never dropped early
    always @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_req <= 1'b0;
            cnt <= 0;
        end else if (i_go && !o_req) begin
            o_req <= 1'b1;
        end else if (o_req && i_gnt) begin
            cnt <= (cnt == HOLD) ? 0 : cnt + 1;
            o_req <= (cnt != HOLD);
        end
    end
endmodule : dmaarb_host_model

/* dma_transfer_arbitration_tb.sv */
`timescale 1ns/10ps
`include "dmaarb_cfg.svh"
module dma_transfer_arbitration_tb;
    localparam int N = `DMAARB_NUM_CH;
    logic i_ref_clk = 1'b0;
    logic i_resetn = 1'b0;
    logic i_input_clock_pin = 1'b1;
    logic [N-1:0] i_ch_req, i_ch_high, i_ch_dbl, i_ch_src_ext, i_ch_dst_ext;
    logic [N-1:0] i_ch_src_io, i_ch_dst_io, i_ch_irq_en, o_ch_elem_done;
    logic [1:0] i_ext_div_m1, i_sleep_level;
    logic [3:0] i_ext_wait;
    logic [`DMAARB_DATA_W-1:0] i_rd_data, o_wr_data, wdata;
    logic [2:0] o_ch_idx;
    logic i_dual_subsys, i_host_access_port_req, host_go, fifo_seen;
    logic o_ch_active, o_rd_stb, o_wr_stb, o_word_half, o_fifo_sel;
    logic o_host_access_port_gnt, o_dma_clk_en, o_dma_clk_sel_pin, o_wake_irq;
    int fail_count = 0, comparisons = 0, cyc = 0, t0 = 0, dur = 0, halves = 0, wakes = 0;
    int rem[N] = '{default: 0};
    logic [2:0] order[$];
    dmaarb_core dut (.*);
    dmaarb_host_model host (
        .i_ref_clk(i_ref_clk),
        .i_resetn(i_resetn),
        .i_go(host_go),
        .i_gnt(o_host_access_port_gnt),
        .o_req(i_host_access_port_req)
    );
    initial forever #5 i_ref_clk = ~i_ref_clk;
    // ==========================================================
    // compare and close
    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : final_report
    // ==========================================================
    // monitor: pulses are one cycle wide, so sample every falling edge
    always @(negedge i_ref_clk) begin
        cyc++;
        if (o_rd_stb === 1'b1) begin
            t0 = cyc;
            halves++;
            fifo_seen = o_fifo_sel;
            if (o_word_half === 1'b0) order.push_back(o_ch_idx);
        end
        if (o_wr_stb === 1'b1) wdata = o_wr_data;
        if (o_wake_irq === 1'b1) wakes++;
        for (int i = 0; i < N; i++) begin
            if (o_ch_elem_done[i] === 1'b1 && rem[i] > 0) begin
                rem[i]--;
                dur = cyc - t0;
            end
            i_ch_req[i] = (rem[i] > 0);
        end
        // ceiling far above the few hundred cycles the scenarios need
        if (cyc == 20000) begin
            fail_count++;
            final_report();
        end
    end
    task automatic wait_idle();
        int k;
        k = 0;
        while (k < 300 && (rem.sum() != 0 || o_ch_active !== 1'b0)) begin
            @(negedge i_ref_clk);
            k++;
        end
        repeat (3) @(negedge i_ref_clk);
        chk("idle_reached", k < 300, 1);
    endtask : wait_idle
    // ==========================================================
    // scenarios
    task automatic t_basic();
        i_rd_data = 16'hA5C3;
        rem[0] = 1;
        wait_idle();
        chk("int_cycles", dur, 4);
        chk("wr_data", wdata, 16'hA5C3);
        chk("clk_gated", o_dma_clk_en, 1'b0);
    endtask : t_basic
    task automatic t_ext();
        logic [8:0] tbl [7] = '{9'h100, 9'h080, 9'h180, 9'h130, 9'h082, 9'h040, 9'h140};
        int exp_cyc;
        foreach (tbl[k]) begin
            {i_ch_src_ext[1], i_ch_dst_ext[1], i_ch_src_io[1]} = tbl[k][8:6];
            i_dual_subsys = tbl[k][6];
            {i_ext_div_m1, i_ext_wait} = tbl[k][5:0];
            rem[1] = 1;
            wait_idle();
            // dual-part io source counts as on-chip even when marked off-chip
            exp_cyc = (tbl[k][8] && !tbl[k][6]) + tbl[k][7];
            exp_cyc = 4 + exp_cyc * (tbl[k][3:0] + 1) * (tbl[k][5:4] + 1);
            chk("xfer_cycles", dur, exp_cyc);
            chk("fifo_sel", fifo_seen, tbl[k][6]);
        end
        {i_ch_src_ext, i_ch_dst_ext, i_ch_src_io, i_dual_subsys, i_ext_div_m1, i_ext_wait} = '0;
    endtask : t_ext
    task automatic t_prio();
        int exp_ord[8] = '{1, 2, 1, 2, 3, 4, 3, 4};
        order.delete();
        i_ch_high = 6'h06;
        rem = '{0, 2, 2, 2, 2, 0};
        wait_idle();
        chk("grants", order.size(), 8);
        foreach (exp_ord[k]) chk("grant_order", order[k], exp_ord[k]);
        i_ch_high = '0;
    endtask : t_prio
    task automatic t_host();
        int h;
        int n;
        i_ch_dbl[5] = 1'b1;
        rem[5] = 2;
        halves = 0;
        for (n = 0; n < 50 && halves == 0; n++) @(negedge i_ref_clk);
        host_go = 1'b1;
        @(negedge i_ref_clk);
        host_go = 1'b0;
        for (n = 0; n < 50 && o_host_access_port_gnt !== 1'b1; n++) @(negedge i_ref_clk);
        chk("halves_at_grant", halves, 2);
        chk("held_elements", rem[5], 1);
        h = halves;
        for (n = 0; n < 50 && o_host_access_port_gnt === 1'b1; n++) @(negedge i_ref_clk);
        chk("strobes_in_grant", halves, h);
        wait_idle();
        chk("resumed_halves", halves, 4);
        i_ch_dbl = '0;
    endtask : t_host
    task automatic t_sleep();
        for (int lv = 0; lv < 4; lv++) begin
            i_sleep_level = 2'(lv);
            i_ch_irq_en = 6'h01;
            wakes = 0;
            rem[0] = 1;
            wait_idle();
            chk("sleep_cycles", dur, 4);
            chk("clk_source", o_dma_clk_sel_pin, lv == 3);
            if (lv != 0) chk("wake", wakes, 1);
        end
    endtask : t_sleep
    task automatic t_reset();
        int n;
        rem[0] = 1;
        for (n = 0; n < 50 && o_rd_stb !== 1'b1; n++) @(negedge i_ref_clk);
        @(negedge i_ref_clk);
        i_resetn = 1'b0;
        @(negedge i_ref_clk);
        chk("rst_quiet", {o_ch_active, o_rd_stb, o_wr_stb, o_ch_elem_done, o_wake_irq}, 0);
        i_resetn = 1'b1;
        wait_idle();
        chk("rst_cycles", dur, 4);
    endtask : t_reset
    initial begin
        {i_ch_high, i_ch_dbl, i_ch_src_ext, i_ch_dst_ext, i_ch_irq_en} = '0;
        {i_ch_src_io, i_ch_dst_io, i_ext_div_m1, i_sleep_level, i_ext_wait} = '0;
        {i_dual_subsys, host_go, i_rd_data} = '0;
        repeat (4) @(posedge i_ref_clk);
        @(negedge i_ref_clk);
        i_resetn = 1'b1;
        t_basic();
        t_ext();
        t_prio();
        t_host();
        t_sleep();
        t_reset();
        final_report();
    end
endmodule : dma_transfer_arbitration_tb
